// ---- pdsc_pkg.sv ----
// pdsc_pkg: register map, field layouts, reset values and timing for the
// power-delivery source control register bank.
// assumes a 50 MHz ref_clk; all users write pdsc_pkg::name.
package pdsc_pkg;

   // register indices as seen by the serial register engine
   localparam logic [7:0] ADDR_CTL1 = 8'h0b;
   localparam logic [7:0] ADDR_MSG  = 8'h0c;
   localparam logic [7:0] ADDR_CONV = 8'h0d;
   localparam logic [7:0] ADDR_PROT = 8'h0e;

   // second control word layout, msb first
   typedef struct packed {
      logic       hard_reset_cmd;
      logic       advertise_caps_cmd;
      logic       usb_suspend;
      logic       comm_capable_flag;
      logic [2:0] limited_power_flags;
      logic [2:0] touch_current;
      logic [1:0] touch_temp;
      logic       unchunked_ext_flag;
      logic       rsvd;
      logic       caps_repeat_sel;
      logic       gate_drive_enable;
   } pdsc_msg_s;

   // third control word layout, msb first
   typedef struct packed {
      logic       light_load_mode_sel;
      logic       spread_spectrum_en;
      logic [2:0] off_delay;
      logic [1:0] multi_pin_four_func;
      logic [2:0] multi_pin_three_func;
      logic [2:0] multi_pin_two_func;
      logic [2:0] multi_pin_one_func;
   } pdsc_conv_s;

   // fixed supply profile flag bits 28, 26 and 24
   typedef struct packed {
      logic usb_suspend;
      logic comm_capable;
      logic unchunked_ext;
   } pdsc_pdo_flags_s;

   // extended source capability bytes 12, 13 and 20
   typedef struct packed {
      logic [7:0] byte12;
      logic [7:0] byte13;
      logic [7:0] byte20;
   } pdsc_ext_caps_s;

   // single-bit write request toward the external converter
   typedef struct packed {
      logic       req;
      logic [7:0] addr;
      logic [2:0] bitpos;
      logic       val;
   } pdsc_conv_wr_s;

   // one multipurpose pin: out level and output enable
   typedef struct packed {
      logic out;
      logic oe;
   } pdsc_pin_s;

   // reset values
   localparam logic [3:0]  CTL1_RST = 4'h1;
   localparam logic [15:0] MSG_RST  = 16'h0a08;
   localparam logic [15:0] CONV_RST = 16'h9031;
   localparam logic        PROT_RST = 1'b0;

   // converter select codes
   localparam logic [2:0] CONV_FAM_A = 3'h0;
   localparam logic [2:0] CONV_FAM_C = 3'h2;
   localparam logic [2:0] CONV_PINS  = 3'h5;
   localparam logic [7:0] CONV_REG_2 = 8'h02;
   localparam logic [7:0] CONV_REG_4 = 8'h04;
   localparam logic [2:0] BIT_MODE_A = 3'h2;
   localparam logic [2:0] BIT_MODE_C = 3'h4;
   localparam logic [2:0] BIT_DITH_A = 3'h4;

   // pin function codes
   localparam logic [1:0] P4_EN   = 2'h1;
   localparam logic [1:0] P4_BATT = 2'h3;
   localparam logic [2:0] P3_ARB  = 3'h0;
   localparam logic [2:0] P3_EN   = 3'h1;
   localparam logic [2:0] P3_ATT  = 3'h2;
   localparam logic [2:0] P3_DLY  = 3'h3;
   localparam logic [2:0] P3_ORI  = 3'h4;
   localparam logic [2:0] P3_SEL3 = 3'h5;
   localparam logic [2:0] P3_PWM  = 3'h7;
   localparam logic [2:0] P2_L12  = 3'h0;
   localparam logic [2:0] P2_ORI  = 3'h1;
   localparam logic [2:0] P2_LOW  = 3'h2;
   localparam logic [2:0] P2_SHR  = 3'h6;
   localparam logic [2:0] P2_BATT = 3'h7;
   localparam logic [2:0] P1_SEL2 = 3'h0;
   localparam logic [2:0] P1_LOW  = 3'h2;
   localparam logic [2:0] P1_OD   = 3'h3;
   localparam logic [2:0] P1_VSEL = 3'h4;

   // timing
   localparam int CLK_NS        = 20;
   localparam int DEGLITCH_US   = 20;
   localparam int DEGLITCH_CYC  = DEGLITCH_US * 1000 / CLK_NS;
   localparam int MS_CYC        = 1000000 / CLK_NS;
   localparam int UVLO_DELAY_MS = 5000;
   localparam int MIN_MS        = 60000;
   localparam int DLY_OUT_MIN   = 22;
   localparam int PWM_FREQ_HZ   = 10000;
   localparam int PWM_CYC       = 1000000000 / (CLK_NS * PWM_FREQ_HZ);

endpackage

// ---- pdsc_regs.sv ----
// pdsc_regs: control register bank of a single-port pd source controller,
// with the pin, timer and converter-write logic those registers steer.
// assumes a serial register engine in front (reg_* port) and a pd policy
// engine beside it; all inputs synchronous to ref_clk.
//
// Contract
// - type-c bit: 0 advertises 3a (330ua pull-up), 1 advertises 1.5a; resets 0
// - converter select resets 001; 000-100 serial converters, 101 pin-driven
// - pin-driven mode: select lines a, a+b, a+b+c; enables low in reset/detach
// - hard reset bit sends hard reset, self-clears once sent
// - capability send bit transmits only in ready state, self-clears after
// - suspend flag to fixed profile bit 28, comm flag to bit 26
// - limited power flags reset 101, fill extended byte 12 bits 2:0
// - touch current to byte 13 bits 2:0, touch temp to byte 20 bits 1:0
// - unchunked flag resets 1, goes to fixed profile bit 24
// - revision 2 sink: capabilities sent twice if repeat bit 0, else once
// - gate drive enable resets 0: output off with pull-down; 1 enables
// - light load bit resets pwm, propagated to the selected converter; only converter codes 000 and 010 get the write
// - dithering resets off, written to converter register 2 bit 4 only
// - off delay resets 010, codes give 0/10/22/40/80/120 minutes
// - pin 4: unused, delayed enable input, thermistor, battery sense
// - deglitched battery low resends capabilities, armed 5 s after uvlo
// - pin 3 function codes as listed, including 10 khz current pwm
// - pin 3 delayed enable keeps driving high 22 minutes after enable drops
// - pin 2 resets to power share; legacy, orientation, low, battery sense
// - pin 1 resets to alert input; profile select, low, release, vsel
// - thermistor trip: shed load if mode 0, else shut down with mid flag
`timescale 1ns/1ps

module pdsc_regs #(
   parameter int MS_CYC  = pdsc_pkg::MS_CYC,
   parameter int PWM_CYC = pdsc_pkg::PWM_CYC
) (
   // clock and reset
   input  wire logic                     ref_clk,
   input  wire logic                     rstn,
   // register port from the serial engine
   input  wire logic                     reg_wr,
   input  wire logic                     reg_rd,
   input  wire logic [7:0]               reg_addr,
   input  wire logic [15:0]              reg_wdata,
   output logic [15:0]                   reg_rdata,
   // policy engine
   input  wire logic                     pe_ready,
   input  wire logic                     hard_reset_sent,
   input  wire logic                     caps_sent,
   input  wire logic                     hard_reset_active,
   input  wire logic                     sink_attached,
   input  wire logic                     cc_flipped,
   input  wire logic [2:0]               active_profile,
   output logic                          hard_reset_req,
   output logic                          caps_send_req,
   output logic                          caps_send_twice,
   output logic                          cc_adv_1p5a,
   output pdsc_pkg::pdsc_pdo_flags_s     pdo_flags,
   output pdsc_pkg::pdsc_ext_caps_s      ext_caps,
   // converter link
   input  wire logic                     conv_ack,
   output logic [2:0]                    converter_sel,
   output pdsc_pkg::pdsc_conv_wr_s       conv_wr,
   output logic                          vout_select_line_a,
   output logic                          vout_select_line_b,
   output logic                          vout_select_line_c,
   output logic                          upstream_en_low,
   output logic                          upstream_mid_low,
   output logic                          upstream_enable_mid_flag,
   // gate driver and protection
   output logic                          isolation_gate_drive,
   output logic                          gate_pulldown,
   input  wire logic                     ntc_trip,
   output logic                          load_shed_req,
   output logic                          thermal_shutdown,
   // multipurpose pins and their sense inputs
   input  wire logic                     pin1_vsel_level,
   input  wire logic                     legacy_12v_req,
   input  wire logic                     share_pull,
   input  wire logic                     arb_drive,
   input  wire logic [7:0]               pwm_duty,
   input  wire logic                     pin3_in,
   input  wire logic                     pin4_in,
   input  wire logic                     batt_low_raw,
   input  wire logic                     uvlo_ok,
   output logic                          device_enable,
   output pdsc_pkg::pdsc_pin_s           pin1,
   output pdsc_pkg::pdsc_pin_s           pin2,
   output pdsc_pkg::pdsc_pin_s           pin3
);

   logic [3:0]           ctl1;
   pdsc_pkg::pdsc_msg_s  msg;
   pdsc_pkg::pdsc_conv_s conv;
   logic                 thermistor_response_sel;
   logic                 pend_mode;
   logic                 pend_dith;
   logic [15:0]          ms_cnt;
   logic                 ms_tick;
   logic [22:0]          hold_ms;
   logic [22:0]          dly_ms;
   logic [22:0]          delay_ms;
   logic                 en_level;
   logic [9:0]           glitch_cnt;
   logic                 batt_low;
   logic                 batt_low_d;
   logic [12:0]          uvlo_ms;
   logic                 batt_armed;
   logic                 batt_mode;
   logic                 batt_pend;
   logic [12:0]          pwm_cnt;
   logic                 pwm_high;
   logic                 non_i2c;
   logic                 sel_ok;

   assign non_i2c = ctl1[2:0] == pdsc_pkg::CONV_PINS;
   assign sel_ok  = reg_wdata[2:0] <= pdsc_pkg::CONV_PINS;

   ////////////////////////////////////////////////////////////////////////////
   // register writes

   // reserved converter codes are refused, the old selection stays
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
         ctl1 <= pdsc_pkg::CTL1_RST;
      else if (reg_wr && reg_addr == pdsc_pkg::ADDR_CTL1)
      begin
         ctl1[3] <= reg_wdata[3];
         if (sel_ok)
            ctl1[2:0] <= reg_wdata[2:0];
      end
   end

   // command bits self-clear; a write in the clearing cycle wins
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
         msg <= pdsc_pkg::MSG_RST;
      else if (reg_wr && reg_addr == pdsc_pkg::ADDR_MSG)
      begin
         msg      <= reg_wdata;
         msg.rsvd <= 1'b0;
      end
      else
      begin
         if (hard_reset_sent)
            msg.hard_reset_cmd <= 1'b0;
         if (caps_sent)
            msg.advertise_caps_cmd <= 1'b0;
      end
   end

   // third and fourth control words
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         conv     <= pdsc_pkg::CONV_RST;
         thermistor_response_sel <= pdsc_pkg::PROT_RST;
      end
      else if (reg_wr && reg_addr == pdsc_pkg::ADDR_CONV)
         conv <= reg_wdata;
      else if (reg_wr && reg_addr == pdsc_pkg::ADDR_PROT)
         thermistor_response_sel <= reg_wdata[15];
   end

   // read data one cycle after the strobe; unmapped reads zero
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
         reg_rdata <= 16'h0000;
      else if (reg_rd)
      begin
         unique case (reg_addr)
            pdsc_pkg::ADDR_CTL1: reg_rdata <= {12'h000, ctl1};
            pdsc_pkg::ADDR_MSG:  reg_rdata <= msg;
            pdsc_pkg::ADDR_CONV: reg_rdata <= conv;
            pdsc_pkg::ADDR_PROT: reg_rdata <= {thermistor_response_sel, 15'h0000};
            default:             reg_rdata <= 16'h0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // policy engine side

   assign hard_reset_req  = msg.hard_reset_cmd;
   assign caps_send_req   = (msg.advertise_caps_cmd | batt_pend) & pe_ready;
   assign caps_send_twice = ~msg.caps_repeat_sel;
   assign cc_adv_1p5a     = ctl1[3];
   assign converter_sel   = ctl1[2:0];
   assign pdo_flags       = {msg.usb_suspend, msg.comm_capable_flag,
                             msg.unchunked_ext_flag};
   assign ext_caps        = {5'h00, msg.limited_power_flags, 5'h00, msg.touch_current,
                             6'h00, msg.touch_temp};

   // gate driver pulled down whenever disabled
   assign isolation_gate_drive = msg.gate_drive_enable & sink_attached;
   assign gate_pulldown        = ~msg.gate_drive_enable;

   // thermistor response
   assign load_shed_req            = ntc_trip & ~thermistor_response_sel;
   assign thermal_shutdown         = ntc_trip & thermistor_response_sel;
   assign upstream_enable_mid_flag = thermal_shutdown;

   ////////////////////////////////////////////////////////////////////////////
   // converter bit writes: any write of the third word re-sends the mode bit on CONV_FAM_A or CONV_FAM_C, plus
   // the dithering bit on CONV_FAM_A; cheaper than tracking changes and harmless to the converter
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         pend_mode <= 1'b0;
         pend_dith <= 1'b0;
      end
      else if (reg_wr && reg_addr == pdsc_pkg::ADDR_CONV)
      begin
         pend_mode <= ctl1[2:0] == pdsc_pkg::CONV_FAM_A ||
                      ctl1[2:0] == pdsc_pkg::CONV_FAM_C;
         pend_dith <= ctl1[2:0] == pdsc_pkg::CONV_FAM_A;
      end
      else if (conv_ack)
      begin
         if (pend_mode)
            pend_mode <= 1'b0;
         else
            pend_dith <= 1'b0;
      end
   end

   // mode bit goes first, dithering bit next
   always_comb
   begin
      conv_wr.req    = pend_mode | pend_dith;
      conv_wr.addr   = pdsc_pkg::CONV_REG_2;
      conv_wr.bitpos = pdsc_pkg::BIT_DITH_A;
      conv_wr.val    = conv.spread_spectrum_en;
      if (pend_mode)
      begin
         conv_wr.val = conv.light_load_mode_sel;
         if (ctl1[2:0] == pdsc_pkg::CONV_FAM_C)
         begin
            conv_wr.addr   = pdsc_pkg::CONV_REG_4;
            conv_wr.bitpos = pdsc_pkg::BIT_MODE_C;
         end
         else
            conv_wr.bitpos = pdsc_pkg::BIT_MODE_A;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // millisecond tick shared by every long timer
   always_ff @(posedge ref_clk)
   begin
      if (!rstn || ms_tick)
         ms_cnt <= 16'h0000;
      else
         ms_cnt <= ms_cnt + 16'h0001;
   end
   assign ms_tick = ms_cnt == 16'(MS_CYC - 1);

   // off delay table, in ms
   always_comb
   begin
      unique case (conv.off_delay)
         3'h1:    delay_ms = 23'(10 * pdsc_pkg::MIN_MS);
         3'h2:    delay_ms = 23'(22 * pdsc_pkg::MIN_MS);
         3'h3:    delay_ms = 23'(40 * pdsc_pkg::MIN_MS);
         3'h4:    delay_ms = 23'(80 * pdsc_pkg::MIN_MS);
         3'h5:    delay_ms = 23'(120 * pdsc_pkg::MIN_MS);
         default: delay_ms = 23'h000000;
      endcase
   end

   // enable input comes from pin 4 or pin 3, whichever is set up for it
   assign en_level = conv.multi_pin_four_func == pdsc_pkg::P4_EN ? pin4_in :
                     conv.multi_pin_three_func == pdsc_pkg::P3_EN ? pin3_in : 1'b1;

   // timers reload while enable is high and count down after it drops
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         hold_ms <= 23'h000000;
         dly_ms  <= 23'h000000;
      end
      else if (en_level)
      begin
         hold_ms <= delay_ms;
         dly_ms  <= 23'(pdsc_pkg::DLY_OUT_MIN * pdsc_pkg::MIN_MS);
      end
      else if (ms_tick)
      begin
         if (hold_ms != 23'h000000)
            hold_ms <= hold_ms - 23'h000001;
         if (dly_ms != 23'h000000)
            dly_ms <= dly_ms - 23'h000001;
      end
   end

   // only the pin 4 enable is stretched by the off delay
   assign device_enable = conv.multi_pin_four_func == pdsc_pkg::P4_EN ?
                          (en_level | hold_ms != 23'h000000) : en_level;

   ////////////////////////////////////////////////////////////////////////////
   // battery sense: deglitch, 5 s arming after uvlo, one update per fall
   assign batt_mode = conv.multi_pin_four_func == pdsc_pkg::P4_BATT ||
                      conv.multi_pin_two_func == pdsc_pkg::P2_BATT;
   assign batt_low  = glitch_cnt == 10'(pdsc_pkg::DEGLITCH_CYC);

   always_ff @(posedge ref_clk)
   begin
      if (!rstn || !batt_low_raw)
         glitch_cnt <= 10'h000;
      else if (!batt_low)
         glitch_cnt <= glitch_cnt + 10'h001;
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rstn || !uvlo_ok)
         uvlo_ms <= 13'h0000;
      else if (ms_tick && !batt_armed)
         uvlo_ms <= uvlo_ms + 13'h0001;
   end
   assign batt_armed = uvlo_ms == 13'(pdsc_pkg::UVLO_DELAY_MS);

   // a new low event beats a capability-sent clear in the same cycle
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         batt_low_d <= 1'b0;
         batt_pend  <= 1'b0;
      end
      else
      begin
         batt_low_d <= batt_low;
         if (batt_low && !batt_low_d && batt_armed && batt_mode)
            batt_pend <= 1'b1;
         else if (caps_sent)
            batt_pend <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // 10 khz current-limit pwm, duty in 1/256 steps
   always_ff @(posedge ref_clk)
   begin
      if (!rstn || pwm_cnt == 13'(PWM_CYC - 1))
         pwm_cnt <= 13'h0000;
      else
         pwm_cnt <= pwm_cnt + 13'h0001;
   end
   assign pwm_high = {11'h000, pwm_cnt, 8'h00} < 32'(pwm_duty) * 32'(PWM_CYC);

   ////////////////////////////////////////////////////////////////////////////
   // pin drives, registered; open-drain pins only ever pull low
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         pin1 <= 2'b00;
         pin2 <= 2'b00;
         pin3 <= 2'b00;
      end
      else
      begin
         unique case (conv.multi_pin_one_func)
            pdsc_pkg::P1_SEL2: pin1 <= {1'b0, active_profile >= 3'h2};
            pdsc_pkg::P1_LOW:  pin1 <= 2'b01;
            pdsc_pkg::P1_VSEL: pin1 <= {1'b0, pin1_vsel_level};
            default:           pin1 <= 2'b00;
         endcase
         unique case (conv.multi_pin_two_func)
            pdsc_pkg::P2_L12:  pin2 <= {1'b0, legacy_12v_req};
            pdsc_pkg::P2_ORI:  pin2 <= {1'b0, ~cc_flipped};
            pdsc_pkg::P2_LOW:  pin2 <= 2'b01;
            pdsc_pkg::P2_SHR:  pin2 <= {1'b0, share_pull};
            default:           pin2 <= 2'b00;
         endcase
         unique case (conv.multi_pin_three_func)
            pdsc_pkg::P3_ARB:  pin3 <= {1'b0, arb_drive};
            pdsc_pkg::P3_ATT:  pin3 <= {1'b0, sink_attached};
            pdsc_pkg::P3_DLY:  pin3 <= {1'b1, en_level | dly_ms != 23'h000000};
            pdsc_pkg::P3_ORI:  pin3 <= {1'b0, ~cc_flipped};
            pdsc_pkg::P3_SEL3: pin3 <= {1'b0, active_profile >= 3'h3};
            pdsc_pkg::P3_PWM:  pin3 <= {1'b0, ~pwm_high};
            default:           pin3 <= 2'b00;
         endcase
      end
   end

   // pin-driven converter: profile select lines and upstream enables
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         vout_select_line_a <= 1'b0;
         vout_select_line_b <= 1'b0;
         vout_select_line_c <= 1'b0;
         upstream_en_low    <= 1'b0;
         upstream_mid_low   <= 1'b0;
      end
      else
      begin
         vout_select_line_a <= non_i2c && active_profile inside {3'h2, 3'h3, 3'h4};
         vout_select_line_b <= non_i2c && active_profile inside {3'h3, 3'h4};
         vout_select_line_c <= non_i2c && active_profile == 3'h4;
         upstream_en_low    <= non_i2c && (hard_reset_active || !sink_attached);
         upstream_mid_low   <= non_i2c && (hard_reset_active || !sink_attached);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   sequence s_en_drop;
      $fell(en_level) && conv.multi_pin_three_func == pdsc_pkg::P3_DLY;
   endsequence
   sequence s_pin3_held;
      (pin3 == 2'b11) [*4];
   endsequence

   a_hard_reset_clear: assert property (hard_reset_sent && !reg_wr |=> !hard_reset_req)
      else $error("hard reset bit not cleared after send");
   a_caps_gate: assert property (caps_send_req |-> pe_ready)
      else $error("capability send outside ready state");
   a_sel_lines: assert property (non_i2c && active_profile == 3'h4 |=>
      vout_select_line_a && vout_select_line_b && vout_select_line_c)
      else $error("select lines wrong for fourth profile");
   a_gate_off: assert property (!msg.gate_drive_enable |->
      !isolation_gate_drive && gate_pulldown)
      else $error("gate driver active while disabled");
   a_ntc_shed: assert property (ntc_trip && !thermistor_response_sel |->
      load_shed_req && !thermal_shutdown)
      else $error("thermistor response wrong");
   a_conv_addr: assert property (conv_wr.req && pend_mode &&
      ctl1[2:0] == pdsc_pkg::CONV_FAM_C |-> conv_wr.addr == 8'h04 && conv_wr.bitpos == 3'h4)
      else $error("light load write misaddressed");
   a_reset_vals: assert property ($rose(rstn) |-> msg == 16'h0a08 && conv == 16'h9031
      && ctl1 == 4'h1)
      else $error("reset value wrong");
   a_batt_armed: assert property ($rose(batt_pend) |-> $past(batt_armed) && $past(batt_mode))
      else $error("battery update while not armed");
   a_dly_hold: assert property (s_en_drop ##1 conv.multi_pin_three_func == pdsc_pkg::P3_DLY
      |=> s_pin3_held)
      else $error("delayed enable released early");

endmodule

// ---- pdsc_pe_model.sv ----
// pdsc_pe_model: policy engine and converter stand-in for pdsc_regs.
// assumes it shares ref_clk and rstn with the register bank.
`timescale 1ns/1ps
module pdsc_pe_model (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic rstn,
   // requests from the bank
   input  wire logic hard_reset_req,
   input  wire logic caps_send_req,
   input  wire logic conv_req,
   // completions back to the bank
   output logic      hard_reset_sent,
   output logic      caps_sent,
   output logic      conv_ack
);
   // one pulse per request; the gap lets the bit clear before a re-look
   always_ff @(posedge ref_clk)
   begin
      hard_reset_sent <= rstn & hard_reset_req & ~hard_reset_sent;
      caps_sent       <= rstn & caps_send_req & ~caps_sent;
      conv_ack        <= rstn & conv_req & ~conv_ack;
   end
endmodule

// ---- pdsc_regs_bench.sv ----
// pdsc_regs_bench: self-checking bench for the pd source control registers.
// assumes pdsc_pkg and pdsc_pe_model are compiled first.
`timescale 1ns/1ps
module pdsc_regs_bench;
   logic ref_clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, pe_ready = 0, sink_attached = 0;
   logic hard_reset_active = 0, cc_flipped = 0, ntc_trip = 0, pin3_in = 0, pin4_in = 0;
   logic pin1_vsel_level = 0, legacy_12v_req = 0, share_pull = 0, arb_drive = 0;
   logic batt_low_raw = 0, uvlo_ok = 1, hard_reset_sent, caps_sent, conv_ack, device_enable;
   logic [7:0] reg_addr = 0, pwm_duty = 0;
   logic [15:0] reg_wdata = 0, reg_rdata;
   logic [2:0] active_profile = 1, pdo_flags, converter_sel;
   logic [1:0] pin1, pin2, pin3;
   logic [23:0] ext_caps;
   logic hard_reset_req, caps_send_req, caps_send_twice, cc_adv_1p5a, vsa, vsb, vsc;
   logic upstream_en_low, upstream_mid_low, upstream_enable_mid_flag;
   logic isolation_gate_drive, gate_pulldown, load_shed_req, thermal_shutdown;
   pdsc_pkg::pdsc_conv_wr_s conv_wr, acks[$];
   int n_mismatch = 0, samples_checked = 0, cycles = 0;
   // rows: address, write data, expected read-back
   logic [39:0] rows [5] = '{{8'h0b,16'h000e,16'h0009}, {8'h0c,16'h3fec,16'h3fe8},
      {8'h0d,16'h5a5a,16'h5a5a}, {8'h0e,16'hffff,16'h8000}, {8'h20,16'h1234,16'h0000}};

   always #10 ref_clk = ~ref_clk;
   pdsc_regs #(.MS_CYC(10), .PWM_CYC(64)) i_pdsc_regs (.ref_clk, .rstn, .reg_wr, .reg_rd,
      .reg_addr, .reg_wdata, .reg_rdata, .pe_ready, .hard_reset_sent, .caps_sent,
      .hard_reset_active, .sink_attached, .cc_flipped, .active_profile, .hard_reset_req,
      .caps_send_req, .caps_send_twice, .cc_adv_1p5a, .pdo_flags, .ext_caps, .conv_ack,
      .converter_sel, .conv_wr, .vout_select_line_a(vsa), .vout_select_line_b(vsb),
      .vout_select_line_c(vsc), .upstream_en_low, .upstream_mid_low,
      .upstream_enable_mid_flag, .isolation_gate_drive, .gate_pulldown, .ntc_trip,
      .load_shed_req, .thermal_shutdown, .pin1_vsel_level, .legacy_12v_req, .share_pull,
      .arb_drive, .pwm_duty, .pin3_in, .pin4_in, .batt_low_raw, .uvlo_ok,
      .device_enable, .pin1, .pin2, .pin3);
   pdsc_pe_model i_pdsc_pe_model (.ref_clk, .rstn, .hard_reset_req, .caps_send_req,
      .conv_req(conv_wr.req), .hard_reset_sent, .caps_sent, .conv_ack);

   ////////////////////////////////////////////////////////////////////////////////
   // converter writes retired by the model, in order
   always @(posedge ref_clk)
   begin
      cycles++;
      if (conv_ack && conv_wr.req)
         acks.push_back(conv_wr);
      if (cycles == 55000)
      begin
         n_mismatch++;
         print_verdict;
      end
   end

   task chk(input string nm, input logic [23:0] exp, got);
      samples_checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("BAD %s exp %h got %h", nm, exp, got);
      end
   endtask
   // strobes rise and fall 2 ns after an edge so the edge sees them settled
   task wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge ref_clk) #2 {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
      @(posedge ref_clk) #2 reg_wr = 0;
   endtask
   task rd(input logic [7:0] a, input logic [15:0] e);
      @(posedge ref_clk) #2 {reg_rd, reg_addr} = {1'b1, a};
      @(posedge ref_clk) #2 reg_rd = 0;
      chk("reg_rdata", e, reg_rdata);
   endtask
   task rst;
      rstn = 0;
      repeat (12) @(posedge ref_clk);
      #2 rstn = 1;
   endtask
   task print_verdict;
      $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      rst;
      foreach (rows[i])
      begin
         wr(rows[i][39:32], rows[i][31:16]);
         rd(rows[i][39:32], rows[i][15:0]);
      end
      chk("flags", 4'hf, {cc_adv_1p5a, pdo_flags});
      chk("ext_caps", 24'h070702, ext_caps);
      // second reset mid-run brings every field home
      rst;
      rd(8'h0b, 16'h0001);
      rd(8'h0c, 16'h0a08);
      rd(8'h0d, 16'h9031);
      rd(8'h0e, 16'h0000);
      chk("reset outs", 3'b110, {caps_send_twice, gate_pulldown, isolation_gate_drive});
      wr(8'h0c, 16'h8a08);
      chk("hard_reset_req", 1, hard_reset_req);
      repeat (5) @(posedge ref_clk);
      rd(8'h0c, 16'h0a08);
      // capability send waits for the ready state
      wr(8'h0c, 16'h4a08);
      repeat (3) @(posedge ref_clk);
      chk("caps_send_req", 0, caps_send_req);
      rd(8'h0c, 16'h4a08);
      pe_ready = 1;
      repeat (5) @(posedge ref_clk);
      rd(8'h0c, 16'h0a08);
      // pin-driven converter: thermometer select lines
      wr(8'h0b, 16'h0005);
      sink_attached = 1;
      for (int p = 1; p < 5; p++)
      begin
         active_profile = p[2:0];
         repeat (3) @(posedge ref_clk);
         #2 chk("select", {p > 1, p > 2, p > 3}, {vsa, vsb, vsc});
      end
      wr(8'h0c, 16'h0a09);
      chk("gate", 2'b10, {isolation_gate_drive, gate_pulldown});
      sink_attached = 0;
      repeat (3) @(posedge ref_clk);
      chk("upstream", 5'b11101, {upstream_en_low, upstream_mid_low, converter_sel});
      // serial converter: mode then dithering, both retired by the model
      wr(8'h0b, 16'h0000);
      wr(8'h0d, 16'h4000);
      repeat (10) @(posedge ref_clk);
      #2 chk("mode wr", {1'b1, 8'h02, 3'd2, 1'b0}, acks[0]);
      chk("dither wr", {1'b1, 8'h02, 3'd4, 1'b1}, acks[1]);
      // pin 3 delayed enable outlives the pin 4 enable; pins 1, 2 low
      pin4_in = 1;
      wr(8'h0d, 16'h0ad2);
      rd(8'h0d, 16'h0ad2);
      pin4_in = 0;
      repeat (3) @(posedge ref_clk);
      #2 chk("pins", 7'b1101011, {pin3, pin2, pin1, device_enable});
      ntc_trip = 1;
      repeat (2) @(posedge ref_clk);
      chk("ntc shed", 3'b100, {load_shed_req, thermal_shutdown, upstream_enable_mid_flag});
      wr(8'h0e, 16'h8000);
      chk("ntc stop", 3'b011, {load_shed_req, thermal_shutdown, upstream_enable_mid_flag});
      // battery low once armed after uvlo raises a pending capability send
      pe_ready = 0;
      wr(8'h0d, 16'h0038);
      repeat (50000) @(posedge ref_clk);
      #2 batt_low_raw = 1;
      repeat (1005) @(posedge ref_clk);
      #2 chk("batt held", 0, caps_send_req);
      pe_ready = 1;
      #1 chk("batt caps", 1, caps_send_req);
      print_verdict;
   end
endmodule
